// *** src/pd_pkg.sv ***
package pd_pkg;

  // ------------------------------------------------------------------
  // Widths and register space
  // ------------------------------------------------------------------
  localparam int PD_AW = 5;
  localparam int PD_DW = 8;
  localparam int PD_NREG = 32;
  localparam int PD_NCTRL = 30;
  localparam logic [PD_AW-1:0] PD_DEV_STATUS = 5'h1e;
  localparam logic [PD_AW-1:0] PD_DEV_MASK = 5'h1f;
  localparam logic [PD_DW-1:0] PD_DEV_RST = 8'h00;

  // ------------------------------------------------------------------
  // Pin synchroniser reset image
  // ------------------------------------------------------------------
  // {cs_n, rd_n, wr_n, ale, addr[4:0], data[7:0], hard_reset_n_n, lo, hi, style}
  localparam int PD_SYNC_W = 21;
  localparam logic [PD_SYNC_W-1:0] PD_SYNC_RST = 21'h1c_0008;

  // ------------------------------------------------------------------
  // Controller register map
  // ------------------------------------------------------------------
  localparam int PD_HAW = 4;
  localparam logic [PD_HAW-1:0] PD_H_CFG = 4'h0;
  localparam logic [PD_HAW-1:0] PD_H_ADDR = 4'h1;
  localparam logic [PD_HAW-1:0] PD_H_WDATA = 4'h2;
  localparam logic [PD_HAW-1:0] PD_H_CMD = 4'h3;
  localparam logic [PD_HAW-1:0] PD_H_RDATA = 4'h4;
  localparam logic [PD_HAW-1:0] PD_H_STAT = 4'h5;
  localparam logic [PD_HAW-1:0] PD_H_IRQ = 4'h6;
  localparam logic [PD_HAW-1:0] PD_H_MASK = 4'h7;
  localparam int PD_CFG_NONMUX = 0;
  localparam int PD_CFG_MOTO = 1;
  localparam int PD_CFG_HARD_RESET_N = 2;
  localparam int PD_CMD_GO = 0;
  localparam int PD_CMD_READ = 1;
  localparam int PD_IRQ_DONE = 0;
  localparam int PD_IRQ_DEV = 1;
  localparam logic [2:0] PD_CFG_RST = 3'h0;
  localparam logic [1:0] PD_IRQ_RST = 2'h0;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int PD_CLK_PERIOD_NS = 4;
  localparam int PD_ALE_NS = 12;
  localparam int PD_STROBE_NS = 32;
  localparam int PD_RECOVER_NS = 16;
  localparam int PD_ALE_CYC =
    (PD_ALE_NS + PD_CLK_PERIOD_NS - 1) / PD_CLK_PERIOD_NS;
  localparam int PD_STROBE_CYC =
    (PD_STROBE_NS + PD_CLK_PERIOD_NS - 1) / PD_CLK_PERIOD_NS;
  localparam int PD_RECOVER_CYC =
    (PD_RECOVER_NS + PD_CLK_PERIOD_NS - 1) / PD_CLK_PERIOD_NS;
  localparam int PD_CW = 4;

  typedef enum logic [2:0] {
    PD_H_IDLE,
    PD_H_ASETUP,
    PD_H_AHOLD,
    PD_H_STROBE,
    PD_H_RECOVER
  } pd_host_state_t;

endpackage : pd_pkg

// *** src/pd_bus_if.sv ***
interface pd_bus_if;
  import pd_pkg::*;

  // ------------------------------------------------------------------
  // Port pins
  // ------------------------------------------------------------------
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic ale;
  logic [PD_AW-1:0] addr_lines;
  logic [PD_DW-1:0] host_data;
  logic host_data_oe;
  logic [PD_DW-1:0] dev_data;
  logic dev_data_oe;
  logic [PD_DW-1:0] bus_data;
  logic int_n_oe;
  logic int_n;
  logic hard_reset_n;
  logic port_select_lo;
  logic port_select_hi;
  logic bus_style_select;
  logic spare_input;

  // Wire resolution; an idle bus reads as zero
  assign bus_data = host_data_oe ? host_data :
                    (dev_data_oe ? dev_data : 8'h00);
  // Open drain with pull-up
  assign int_n = ~int_n_oe;

  modport dev (
    input cs_n, rd_n, wr_n, ale, addr_lines, bus_data, hard_reset_n,
    input port_select_lo, port_select_hi, bus_style_select, spare_input,
    output dev_data, dev_data_oe, int_n_oe
  );

  modport host (
    output cs_n, rd_n, wr_n, ale, addr_lines, host_data, host_data_oe,
    output hard_reset_n, port_select_lo, port_select_hi,
    output bus_style_select, spare_input,
    input bus_data, int_n
  );

endinterface : pd_bus_if

// *** src/pd_dev_end.sv ***
// Notes on behaviour
// - Nonmuxed: address from dedicated lines, pins data
// - Muxed: host holds dedicated address lines low
// - Muxed: shared pins carry address then data
// - Muxed: address latched on latch strobe rise
// - Nonmuxed: host ties latch strobe low
// - Access only while chip select low
// - Style strap high: strobe plus direction timing
// - Style strap: pins become strobe, latch, direction
// - Serial control: host holds style strap low
// - Hard reset clears every control bit
// - Interrupt pin pulled low on enabled status
// - Host ties unassigned inputs low
// - Data strobe active low in strobe style
// - Direction low requests a write
module pd_dev_end
  import pd_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Port pins
  pd_bus_if.dev bus,
  // User side
  input wire logic [PD_DW-1:0] dev_events,
  output logic [PD_NCTRL-1:0][PD_DW-1:0] ctrl_regs_r,
  output logic [PD_DW-1:0] status_r,
  output logic [PD_DW-1:0] mask_r
);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [PD_SYNC_W-1:0] sync1_r;
  logic [PD_SYNC_W-1:0] sync2_r;
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic ale_s;
  logic [PD_AW-1:0] addr_s;
  logic [PD_DW-1:0] data_s;
  logic hard_reset_n_n_s;
  logic sel_lo_s;
  logic sel_hi_s;
  logic style_s;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      sync1_r <= PD_SYNC_RST;
      sync2_r <= PD_SYNC_RST;
    end
    else
    begin
      sync1_r <= {bus.cs_n, bus.rd_n, bus.wr_n, bus.ale, bus.addr_lines,
                  bus.bus_data, bus.hard_reset_n, bus.port_select_lo,
                  bus.port_select_hi, bus.bus_style_select};
      sync2_r <= sync1_r;
    end
  end

  assign {cs_n_s, rd_n_s, wr_n_s, ale_s, addr_s, data_s, hard_reset_n_n_s,
          sel_lo_s, sel_hi_s, style_s} = sync2_r;

  // ------------------------------------------------------------------
  // Strobe history
  // ------------------------------------------------------------------
  logic cs_n_prev_r;
  logic rd_n_prev_r;
  logic wr_n_prev_r;
  logic ale_prev_r;
  logic [PD_DW-1:0] data_prev_r;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      cs_n_prev_r <= 1'b1;
      rd_n_prev_r <= 1'b1;
      wr_n_prev_r <= 1'b1;
      ale_prev_r <= 1'b0;
      data_prev_r <= PD_DEV_RST;
    end
    else
    begin
      cs_n_prev_r <= cs_n_s;
      rd_n_prev_r <= rd_n_s;
      wr_n_prev_r <= wr_n_s;
      ale_prev_r <= ale_s;
      data_prev_r <= data_s;
    end
  end

  // ------------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------------
  logic parallel;
  logic muxed;
  logic moto;
  logic rd_active;
  logic wr_commit;
  logic [PD_AW-1:0] addr_lat_r;
  logic [PD_AW-1:0] acc_addr;

  assign parallel = ~sel_hi_s;
  assign muxed = ~sel_lo_s;
  assign moto = style_s;

  // Strobe style: read pin is data strobe, write pin is direction
  assign rd_active = parallel & ~cs_n_s & ~rd_n_s
                     & (moto ? wr_n_s : 1'b1);
  // Write lands when its strobe ends, data sampled one cycle earlier
  assign wr_commit = parallel & ~cs_n_prev_r
                     & (moto ? (~rd_n_prev_r & rd_n_s & ~wr_n_prev_r)
                             : (~wr_n_prev_r & wr_n_s));

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      addr_lat_r <= '0;
    else if (parallel && muxed && ale_s && !ale_prev_r)
      addr_lat_r <= data_s[PD_AW-1:0];
  end

  // Dedicated lines ignored in muxed mode
  assign acc_addr = muxed ? addr_lat_r : addr_s;

  function automatic logic pd_hit(
    input logic [PD_AW-1:0] a,
    input logic [PD_AW-1:0] idx
  );
    pd_hit = (a == idx);
  endfunction : pd_hit

  // ------------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PD_NCTRL; gi++)
    begin : g_ctrl
      always_ff @(posedge sys_clk)
      begin
        if (!reset_n || !hard_reset_n_n_s)
          ctrl_regs_r[gi] <= PD_DEV_RST;
        else if (wr_commit && pd_hit(acc_addr, PD_AW'(gi)))
          ctrl_regs_r[gi] <= data_prev_r;
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Status, mask and interrupt pin
  // ------------------------------------------------------------------
  logic [PD_DW-1:0] status_clr;
  logic int_oe_r;

  assign status_clr = (wr_commit && pd_hit(acc_addr, PD_DEV_STATUS)) ?
                      data_prev_r : '0;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n || !hard_reset_n_n_s)
      status_r <= PD_DEV_RST;
    else
      status_r <= (status_r & ~status_clr) | dev_events; // Set wins
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n || !hard_reset_n_n_s)
      mask_r <= PD_DEV_RST;
    else if (wr_commit && pd_hit(acc_addr, PD_DEV_MASK))
      mask_r <= data_prev_r;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      int_oe_r <= 1'b0;
    else
      int_oe_r <= |(status_r & mask_r);
  end

  assign bus.int_n_oe = int_oe_r;

  // ------------------------------------------------------------------
  // Read drive
  // ------------------------------------------------------------------
  logic [PD_DW-1:0] rd_val;
  logic [PD_DW-1:0] dout_r;
  logic dout_oe_r;

  always_comb
  begin
    rd_val = PD_DEV_RST;
    if (pd_hit(acc_addr, PD_DEV_STATUS))
      rd_val = status_r;
    else if (pd_hit(acc_addr, PD_DEV_MASK))
      rd_val = mask_r;
    else
      rd_val = ctrl_regs_r[acc_addr];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      dout_r <= PD_DEV_RST;
      dout_oe_r <= 1'b0;
    end
    else
    begin
      dout_r <= rd_val;
      dout_oe_r <= rd_active;
    end
  end

  assign bus.dev_data = dout_r;
  assign bus.dev_data_oe = dout_oe_r;

endmodule : pd_dev_end

// *** src/pd_host_end.sv ***
module pd_host_end
  import pd_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Port pins
  pd_bus_if.host bus,
  // Software port
  input wire logic [PD_HAW-1:0] sw_addr,
  input wire logic [PD_DW-1:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [PD_DW-1:0] sw_rdata_r,
  output logic host_irq_r
);

  // ------------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------------
  logic [2:0] cfg_r;
  logic [PD_AW-1:0] addr_r;
  logic [PD_DW-1:0] wdata_r;
  logic [PD_DW-1:0] rdata_r;
  logic [1:0] irq_r;
  logic [1:0] mask_r;
  logic op_read_r;
  logic start;
  logic done;
  logic [1:0] irq_clr;
  logic [1:0] int_s2_r;
  logic [PD_DW-1:0] din_s1_r;
  logic [PD_DW-1:0] din_s2_r;
  pd_host_state_t state_r;
  logic [PD_CW-1:0] cnt_r;

  assign start = sw_wr && (sw_addr == PD_H_CMD) && sw_wdata[PD_CMD_GO]
                 && (state_r == PD_H_IDLE);
  assign irq_clr = (sw_wr && sw_addr == PD_H_IRQ) ? sw_wdata[1:0] : 2'h0;
  assign done = (state_r == PD_H_RECOVER) && (cnt_r == '0);

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      cfg_r <= PD_CFG_RST;
      addr_r <= '0;
      wdata_r <= '0;
      mask_r <= PD_IRQ_RST;
      op_read_r <= 1'b0;
    end
    else if (sw_wr)
    begin
      if (sw_addr == PD_H_CFG)
        cfg_r <= sw_wdata[2:0];
      else if (sw_addr == PD_H_ADDR)
        addr_r <= sw_wdata[PD_AW-1:0];
      else if (sw_addr == PD_H_WDATA)
        wdata_r <= sw_wdata;
      else if (sw_addr == PD_H_MASK)
        mask_r <= sw_wdata[1:0];
      else if (start)
        op_read_r <= sw_wdata[PD_CMD_READ];
    end
  end

  // ------------------------------------------------------------------
  // Interrupt status
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      irq_r <= PD_IRQ_RST;
      host_irq_r <= 1'b0;
    end
    else
    begin
      // Set wins over a clear in the same cycle
      irq_r <= (irq_r & ~irq_clr) | {~int_s2_r[1], done};
      host_irq_r <= |(irq_r & mask_r);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      sw_rdata_r <= '0;
    else if (!sw_rd)
      sw_rdata_r <= '0;
    else if (sw_addr == PD_H_CFG)
      sw_rdata_r <= {5'h00, cfg_r};
    else if (sw_addr == PD_H_ADDR)
      sw_rdata_r <= {3'h0, addr_r};
    else if (sw_addr == PD_H_WDATA)
      sw_rdata_r <= wdata_r;
    else if (sw_addr == PD_H_RDATA)
      sw_rdata_r <= rdata_r;
    else if (sw_addr == PD_H_STAT)
      sw_rdata_r <= {6'h00, int_s2_r[1], state_r != PD_H_IDLE};
    else if (sw_addr == PD_H_IRQ)
      sw_rdata_r <= {6'h00, irq_r};
    else if (sw_addr == PD_H_MASK)
      sw_rdata_r <= {6'h00, mask_r};
    else
      sw_rdata_r <= '0;
  end

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      int_s2_r <= 2'h3;
      din_s1_r <= '0;
      din_s2_r <= '0;
    end
    else
    begin
      int_s2_r <= {int_s2_r[0], bus.int_n};
      din_s1_r <= bus.bus_data;
      din_s2_r <= din_s1_r;
    end
  end

  // ------------------------------------------------------------------
  // Access sequencer
  // ------------------------------------------------------------------
  logic cs_n_r;
  logic rd_n_r;
  logic wr_n_r;
  logic ale_r;
  logic [PD_DW-1:0] hd_r;
  logic hd_oe_r;
  logic muxed;
  logic moto;

  assign muxed = ~cfg_r[PD_CFG_NONMUX];
  assign moto = cfg_r[PD_CFG_MOTO];

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state_r <= PD_H_IDLE;
      cnt_r <= '0;
      cs_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      ale_r <= 1'b0;
      hd_r <= '0;
      hd_oe_r <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      case (state_r)
        PD_H_IDLE:
          if (start && muxed)
          begin
            hd_r <= {3'h0, addr_r};
            hd_oe_r <= 1'b1;
            cnt_r <= PD_CW'(PD_ALE_CYC - 1);
            state_r <= PD_H_ASETUP;
          end
          else if (start)
          begin
            cnt_r <= PD_CW'(PD_STROBE_CYC - 1);
            cs_n_r <= 1'b0;
            rd_n_r <= ~(moto | sw_wdata[PD_CMD_READ]);
            wr_n_r <= sw_wdata[PD_CMD_READ];
            hd_r <= wdata_r;
            hd_oe_r <= ~sw_wdata[PD_CMD_READ];
            state_r <= PD_H_STROBE;
          end
        PD_H_ASETUP:
          if (cnt_r == '0)
          begin
            ale_r <= 1'b1;
            cnt_r <= PD_CW'(PD_ALE_CYC - 1);
            state_r <= PD_H_AHOLD;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        PD_H_AHOLD:
          if (cnt_r == '0)
          begin
            ale_r <= 1'b0;
            cnt_r <= PD_CW'(PD_STROBE_CYC - 1);
            cs_n_r <= 1'b0;
            rd_n_r <= ~(moto | op_read_r);
            wr_n_r <= op_read_r;
            hd_r <= wdata_r;
            hd_oe_r <= ~op_read_r;
            state_r <= PD_H_STROBE;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        PD_H_STROBE:
          if (cnt_r == '0)
          begin
            if (op_read_r)
              rdata_r <= din_s2_r;
            cs_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            cnt_r <= PD_CW'(PD_RECOVER_CYC - 1);
            state_r <= PD_H_RECOVER;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        PD_H_RECOVER:
          // Write data held while the device sees the strobe end
          if (cnt_r == '0)
          begin
            hd_oe_r <= 1'b0;
            state_r <= PD_H_IDLE;
          end
          else
            cnt_r <= cnt_r - 1'b1;
        default:
          state_r <= PD_H_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------------
  logic [PD_AW-1:0] apin_r;
  logic ale_pin_r;
  logic hard_reset_n_n_r;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      apin_r <= '0;
      ale_pin_r <= 1'b0;
      hard_reset_n_n_r <= 1'b1;
    end
    else
    begin
      apin_r <= muxed ? '0 : addr_r;
      ale_pin_r <= muxed & ale_r;
      hard_reset_n_n_r <= ~cfg_r[PD_CFG_HARD_RESET_N];
    end
  end

  assign bus.cs_n = cs_n_r;
  assign bus.rd_n = rd_n_r;
  assign bus.wr_n = wr_n_r;
  assign bus.ale = ale_pin_r;
  assign bus.addr_lines = apin_r;
  assign bus.host_data = hd_r;
  assign bus.host_data_oe = hd_oe_r;
  assign bus.hard_reset_n = hard_reset_n_n_r;
  assign bus.port_select_lo = cfg_r[PD_CFG_NONMUX];
  assign bus.port_select_hi = 1'b0; // Parallel only, so style strap free
  assign bus.bus_style_select = moto;
  assign bus.spare_input = 1'b0;

endmodule : pd_host_end

// *** tb/pd_bus_chk.sv ***
module pd_bus_chk
  import pd_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Host pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ale,
  input wire logic [PD_AW-1:0] addr_lines,
  input wire logic host_data_oe,
  input wire logic port_select_lo,
  input wire logic port_select_hi,
  input wire logic bus_style_select,
  input wire logic spare_input,
  // Shared and device pins
  input wire logic [PD_DW-1:0] bus_data,
  input wire logic dev_data_oe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // ------------------------------------------------------------------
  // Access phases
  // ------------------------------------------------------------------
  sequence s_latch_pulse;
    ale [*3] ##1 !ale;
  endsequence
  sequence s_strobe_hold;
    (!cs_n) [*8] ##1 cs_n;
  endsequence

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  chk_ale_pulse: assert property ($rose(ale) |-> s_latch_pulse)
    else $error("latch strobe width wrong");
  chk_addr_setup: assert property
    ($rose(ale) |-> host_data_oe && $stable(bus_data))
    else $error("address not steady at latch");
  chk_ale_nonmux: assert property (port_select_lo |-> !ale)
    else $error("latch strobe high in nonmuxed mode");
  chk_muxed_addr_low: assert property
    (!port_select_lo && !cs_n |-> addr_lines == 5'h00)
    else $error("dedicated address not low in muxed mode");
  chk_strobe_len: assert property ($fell(cs_n) |-> s_strobe_hold)
    else $error("chip select length wrong");
  chk_oe_needs_read: assert property
    ($rose(dev_data_oe) |-> $past(!cs_n && !rd_n && wr_n, 2))
    else $error("device drove without a read");
  chk_oe_release: assert property
    ($rose(cs_n) |-> ##[1:5] !dev_data_oe)
    else $error("device kept driving after access");
  chk_no_contention: assert property
    (!(dev_data_oe && host_data_oe))
    else $error("both ends drive shared pins");
  chk_sep_strobes: assert property
    (!cs_n && !bus_style_select |-> (rd_n ^ wr_n))
    else $error("separate strobe style broken");
  chk_data_strobe: assert property
    (!cs_n && bus_style_select |-> !rd_n)
    else $error("data strobe not low in access");
  chk_write_drives: assert property
    (!cs_n && !wr_n |-> host_data_oe)
    else $error("write without data driven");
  chk_unused_low: assert property
    (spare_input == 1'b0 && port_select_hi == 1'b0)
    else $error("unused input not low");
endmodule : pd_bus_chk

// *** tb/test_line_interface_parallel_host_port.sv ***
module test_line_interface_parallel_host_port
  import pd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [PD_HAW-1:0] sw_addr = 4'h0;
  logic [PD_DW-1:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [PD_DW-1:0] dev_events = 8'h00;
  logic [PD_DW-1:0] sw_rdata_r;
  logic [PD_DW-1:0] status_r;
  logic [PD_DW-1:0] mask_r;
  logic host_irq_r;
  logic [PD_NCTRL-1:0][PD_DW-1:0] ctrl_regs_r;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  // Model: 0..29 control, 30 status, 31 mask
  int mdl [32];

  pd_bus_if pd_bus_if_inst ();
  pd_host_end pd_host_end_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .bus(pd_bus_if_inst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata_r(sw_rdata_r),
    .host_irq_r(host_irq_r));
  pd_dev_end pd_dev_end_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .bus(pd_bus_if_inst), .dev_events(dev_events),
    .ctrl_regs_r(ctrl_regs_r), .status_r(status_r), .mask_r(mask_r));
  pd_bus_chk pd_bus_chk_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .cs_n(pd_bus_if_inst.cs_n), .rd_n(pd_bus_if_inst.rd_n),
    .wr_n(pd_bus_if_inst.wr_n), .ale(pd_bus_if_inst.ale),
    .addr_lines(pd_bus_if_inst.addr_lines),
    .host_data_oe(pd_bus_if_inst.host_data_oe),
    .port_select_lo(pd_bus_if_inst.port_select_lo),
    .port_select_hi(pd_bus_if_inst.port_select_hi),
    .bus_style_select(pd_bus_if_inst.bus_style_select),
    .spare_input(pd_bus_if_inst.spare_input),
    .bus_data(pd_bus_if_inst.bus_data),
    .dev_data_oe(pd_bus_if_inst.dev_data_oe));

  initial forever #2 sys_clk = ~sys_clk;

  // ------------------------------------------------------------------
  // Reporting
  // ------------------------------------------------------------------
  task automatic cmp8(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : cmp8

  task automatic test_done(input string name);
    $display("test %s finished", name);
  endtask : test_done

  task end_sim;
    $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // Ceiling far above the roughly one thousand cycles the tests need
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      end_sim;
    end
  end

  // ------------------------------------------------------------------
  // Software port and device access
  // ------------------------------------------------------------------
  task automatic host_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
  endtask : host_write

  task automatic host_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata_r;
  endtask : host_read

  // Polling is bounded so a lost access shows as a mismatch, not a hang
  task automatic dev_op(input logic [4:0] a, input logic [7:0] d,
                        input logic rd, output logic [7:0] q);
    logic [7:0] v;
    int i;
    host_write(PD_H_ADDR, {3'h0, a});
    host_write(PD_H_WDATA, d);
    host_write(PD_H_CMD, {6'h00, rd, 1'b1});
    v = 8'h00;
    for (i = 0; i < 40 && v[PD_IRQ_DONE] !== 1'b1; i++)
      host_read(PD_H_IRQ, v);
    cmp8("access done", 8'h01, {7'h00, v[PD_IRQ_DONE]});
    host_write(PD_H_IRQ, 8'h01);
    q = 8'h00;
    if (rd)
      host_read(PD_H_RDATA, q);
  endtask : dev_op

  task automatic check_regs;
    int k;
    for (k = 0; k < PD_NCTRL; k++)
      cmp8("ctrl_regs_r", mdl[k][7:0], ctrl_regs_r[k]);
    cmp8("status_r", mdl[30][7:0], status_r);
    cmp8("mask_r", mdl[31][7:0], mask_r);
  endtask : check_regs

  task automatic dev_wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    dev_op(a, d, 1'b0, q);
    if (a == PD_DEV_STATUS)
      mdl[a] = mdl[a] & ~{24'h00_0000, d};
    else
      mdl[a] = {24'h00_0000, d};
    check_regs;
  endtask : dev_wr

  task automatic dev_rd(input logic [4:0] a);
    logic [7:0] q;
    dev_op(a, 8'h00, 1'b1, q);
    cmp8("device read", mdl[a][7:0], q);
  endtask : dev_rd

  task automatic pulse(input logic [7:0] e, input logic exp_n);
    @(posedge sys_clk);
    dev_events <= e;
    @(posedge sys_clk);
    dev_events <= 8'h00;
    mdl[30] = mdl[30] | {24'h00_0000, e};
    repeat (4) @(posedge sys_clk);
    #1;
    cmp8("int_n", {7'h00, exp_n}, {7'h00, pd_bus_if_inst.int_n});
    check_regs;
  endtask : pulse

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    logic [7:0] v;
    int m;
    int k;
    int a;
    void'($urandom(97594));
    for (k = 0; k < 32; k++)
      mdl[k] = 0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check_regs;
    host_read(PD_H_CFG, v);
    cmp8("host cfg", 8'h00, v);
    host_read(4'hf, v);
    cmp8("unmapped read", 8'h00, v);
    test_done("reset");
    // Muxed and nonmuxed, both strobe styles, edge addresses first
    for (m = 0; m < 4; m++)
    begin
      host_write(PD_H_CFG, m[7:0]);
      for (k = 0; k < 4; k++)
      begin
        a = (k == 0) ? 29 : ((k == 1) ? 0 : $urandom_range(28, 1));
        dev_wr(a[4:0], 8'($urandom));
        dev_rd(a[4:0]);
      end
      test_done("bus mode");
    end
    dev_wr(PD_DEV_MASK, 8'h05);
    host_write(PD_H_MASK, 8'h02);
    pulse(8'h02, 1'b1);
    pulse(8'h04, 1'b0);
    host_read(PD_H_IRQ, v);
    cmp8("host irq", 8'h02, v & 8'h02);
    cmp8("host_irq_r", 8'h01, {7'h00, host_irq_r});
    dev_rd(PD_DEV_STATUS);
    dev_wr(PD_DEV_STATUS, 8'h04);
    cmp8("int_n", 8'h01, {7'h00, pd_bus_if_inst.int_n});
    host_write(PD_H_IRQ, 8'h02);
    repeat (3) @(posedge sys_clk);
    cmp8("host_irq_r", 8'h00, {7'h00, host_irq_r});
    test_done("interrupt");
    host_write(PD_H_CFG, 8'h04);
    repeat (8) @(posedge sys_clk);
    host_write(PD_H_CFG, 8'h00);
    repeat (4) @(posedge sys_clk);
    for (k = 0; k < 32; k++)
      mdl[k] = 0;
    check_regs;
    dev_rd(5'h1d);
    test_done("hard reset");
    end_sim;
  end
endmodule : test_line_interface_parallel_host_port
